// ===== inc/idw_pkg.sv
// Constants and helpers for the identify word generator (words 63-85).
// Assumes a single clock domain and a plain strobe register port.
package idw_pkg;
	// ****************************************
	// Register port
	// ****************************************
	localparam int IDW_AW = 8;
	localparam int IDW_DW = 32;
	localparam logic [7:0] IDW_REG_CTRL = 8'h00;
	localparam logic [7:0] IDW_REG_STAT = 8'h04;
	localparam int IDW_CTRL_MODE_LSB = 0;
	localparam int IDW_CTRL_EN_LSB = 2;
	localparam logic [1:0] IDW_MODE_RST = 2'h0;
	localparam logic [5:0] IDW_EN_RST = 6'h00;
	localparam int IDW_STAT_ACT = 0;
	localparam int IDW_STAT_MODE_LSB = 4;
	localparam int IDW_STAT_EN_LSB = 8;
	localparam int IDW_STAT_CNT_LSB = 16;
	// Enable vector positions
	localparam int IDW_EN_SMART = 0;
	localparam int IDW_EN_SEC = 1;
	localparam int IDW_EN_WC = 2;
	localparam int IDW_EN_LA = 3;
	localparam int IDW_EN_REL = 4;
	localparam int IDW_EN_SRV = 5;
	localparam logic [5:0] IDW_EN_SUP = 6'h3f;
	localparam logic [1:0] IDW_MODE_MAX = 2'h2;
	localparam logic [8:0] IDW_WORDS = 9'h100;
	// ****************************************
	// Word numbers
	// ****************************************
	localparam logic [7:0] IDW_W_MDMA = 8'h3f;
	localparam logic [7:0] IDW_W_PIO = 8'h40;
	localparam logic [7:0] IDW_W_MDMA_MIN = 8'h41;
	localparam logic [7:0] IDW_W_MDMA_REC = 8'h42;
	localparam logic [7:0] IDW_W_PIO_NFC = 8'h43;
	localparam logic [7:0] IDW_W_PIO_FC = 8'h44;
	localparam logic [7:0] IDW_W_PKT_LAT = 8'h47;
	localparam logic [7:0] IDW_W_SRV_LAT = 8'h48;
	localparam logic [7:0] IDW_W_QDEPTH = 8'h4b;
	localparam logic [7:0] IDW_W_MAJOR = 8'h50;
	localparam logic [7:0] IDW_W_MINOR = 8'h51;
	localparam logic [7:0] IDW_W_SUP = 8'h52;
	localparam logic [7:0] IDW_W_SUP2 = 8'h53;
	localparam logic [7:0] IDW_W_EXT = 8'h54;
	localparam logic [7:0] IDW_W_ENA = 8'h55;
	// ****************************************
	// Fixed word contents
	// ****************************************
	localparam logic [2:0] IDW_MDMA_SUP = 3'h7;
	localparam logic [7:0] IDW_PIO_ADV = 8'h03;
	localparam logic [15:0] IDW_T_MDMA_MIN = 16'h0078;
	localparam logic [15:0] IDW_T_MDMA_REC = 16'h0078;
	localparam logic [15:0] IDW_T_PIO_NFC = 16'h00f0;
	localparam logic [15:0] IDW_T_PIO_FC = 16'h0078;
	localparam logic [15:0] IDW_T_PKT_LAT = 16'h0064;
	localparam logic [15:0] IDW_T_SRV_LAT = 16'h0064;
	localparam logic [4:0] IDW_QDEPTH = 5'h01;
	localparam logic [15:0] IDW_MAJOR = 16'h001e;
	localparam logic [15:0] IDW_MINOR = 16'h0017;
	localparam logic [15:0] IDW_SUP = 16'h77ff;
	localparam logic [15:0] IDW_SUP2 = 16'h4011;
	localparam logic [15:0] IDW_EXT = 16'h4000;
	localparam logic [15:0] IDW_ENA_COPY = 16'h761c;
	localparam logic [15:0] IDW_W_NONE = 16'h0000;
	localparam logic [15:0] IDW_W_ALL = 16'hffff;

	function automatic logic [2:0] idw_mode_bits(input logic [1:0] m);
		case (m)
			2'h0: idw_mode_bits = 3'h1;
			2'h1: idw_mode_bits = 3'h2;
			2'h2: idw_mode_bits = 3'h4;
			default: idw_mode_bits = 3'h0;
		endcase
	endfunction
endpackage

// ===== inc/idw_word_if.sv
// Snapshot and word index between the sequencer and the word encoder.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
interface idw_word_if;
	logic [1:0] mode;
	logic [5:0] en;
	logic [7:0] idx;
	logic [15:0] word;
	modport src (output mode, output en, output idx, input word);
	modport enc (input mode, input en, input idx, output word);
endinterface

// ===== rtl/idw_word_enc.sv
// Combinational builder of identify words 63-85 from a state snapshot.
// Assumes the snapshot is held steady by the sequencer.
`timescale 1ns/10ps
module idw_word_enc
	import idw_pkg::*;
(
	idw_word_if.enc wi
);
	always_comb begin
		wi.word = IDW_W_NONE;
		case (wi.idx)
			IDW_W_MDMA: begin
				wi.word[10:8] = idw_mode_bits(wi.mode); // R01
				wi.word[2:0] = IDW_MDMA_SUP; // R02
			end
			IDW_W_PIO: wi.word[7:0] = IDW_PIO_ADV; // R03
			IDW_W_MDMA_MIN: wi.word = IDW_T_MDMA_MIN; // R04
			IDW_W_MDMA_REC: wi.word = IDW_T_MDMA_REC; // R05
			IDW_W_PIO_NFC: wi.word = IDW_T_PIO_NFC; // R06
			IDW_W_PIO_FC: wi.word = IDW_T_PIO_FC; // R07
			IDW_W_PKT_LAT: wi.word = IDW_T_PKT_LAT; // R08
			IDW_W_SRV_LAT: wi.word = IDW_T_SRV_LAT; // R09
			IDW_W_QDEPTH: wi.word[4:0] = IDW_QDEPTH; // R10
			IDW_W_MAJOR: wi.word = IDW_MAJOR; // R11
			IDW_W_MINOR: wi.word = IDW_MINOR; // R12
			IDW_W_SUP: wi.word = IDW_SUP; // R14 R15
			IDW_W_SUP2: wi.word = IDW_SUP2; // R16 R17
			IDW_W_EXT: wi.word = IDW_EXT; // R18
			IDW_W_ENA: begin
				wi.word = IDW_SUP & IDW_ENA_COPY; // R21
				wi.word[8] = wi.en[IDW_EN_SRV]; // R20
				wi.word[7] = wi.en[IDW_EN_REL];
				wi.word[6] = wi.en[IDW_EN_LA];
				wi.word[5] = wi.en[IDW_EN_WC];
				wi.word[1] = wi.en[IDW_EN_SEC]; // R21
				wi.word[0] = wi.en[IDW_EN_SMART];
			end
			// Reserved words and those outside this block
			default: wi.word = IDW_W_NONE; // R22
		endcase
	end
endmodule // idw_word_enc

// ===== rtl/idw_identify.sv
// Identify data generator for words 63-85 of a packet device.
// Assumes start, request and index come from logic on clk.
// Summary of operation
// R01: Word 63 bits 10-8 one-hot show the selected multiword DMA mode.
// R02: Word 63 bits 2-0 fixed support flags; bits 15-11 and 7-3 zero.
// R03: Word 64 low byte fixed advanced PIO modes, high byte zero.
// R04: Word 65 fixed minimum multiword DMA cycle time in ns.
// R05: Word 66 fixed recommended multiword DMA cycle time in ns.
// R06: Word 67 fixed minimum PIO cycle time without flow control.
// R07: Word 68 fixed minimum PIO cycle time with IORDY flow control.
// R08: Word 71 fixed packet-to-release latency; words 69-70 zero.
// R09: Word 72 fixed service-to-BSY-clear latency; words 73-74 zero.
// R10: Word 75 bits 4-0 queue depth; rest and words 76-79 zero.
// R11: Word 80 flags supported major versions; bits 15-5 and 0 zero.
// R12: Word 81 fixed minor version code, never 0000h or FFFFh.
// R13: Words 82 and 83 never both read 0000h or FFFFh.
// R14: Word 82 flags fixed command and feature set support.
// R15: Word 82 flags service, release, look-ahead; bits 15, 11 zero.
// R16: Word 83 bit 15 zero, bit 14 one, other reserved bits zero.
// R17: Word 83 bit 4 status notification, bit 0 microcode download.
// R18: Word 84 is bit 14 one, all else zero.
// R19: Word 85 shows enabled features and follows device state.
// R20: Word 85 bits 8-5 show live service, release, look-ahead, cache.
// R21: Word 85 bits 1-0 security and SMART enable; others copy word 82.
// R22: Reserved words and bits read zero.
// R23: Word bit 15 on data line 15, bit 0 on line 0.
// R24: Variable words come from current state at each transfer.
// R25: Live state is sampled once at transfer start.
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module idw_identify
	import idw_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [IDW_AW-1:0] reg_addr,
	input wire logic [IDW_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [IDW_DW-1:0] reg_rdata,
	input wire logic xfer_start,
	input wire logic word_req,
	input wire logic [7:0] word_idx,
	output logic word_valid,
	output logic [15:0] word_data,
	output logic xfer_active
);
	typedef enum logic {
		IDW_IDLE = 1'b0,
		IDW_SERVE = 1'b1
	} idw_state_e;

	idw_state_e state_reg;
	idw_state_e state_next;
	logic [1:0] mode_reg;
	logic [5:0] en_reg;
	logic [1:0] snap_mode_reg;
	logic [5:0] snap_en_reg;
	logic [8:0] cnt_reg;
	logic [7:0] idx_reg;
	logic word_valid_reg;
	logic [15:0] word_data_reg;
	logic [IDW_DW-1:0] rdata_reg;
	logic [IDW_DW-1:0] stat;
	logic [1:0] wr_mode;
	logic take;
	logic last;

	idw_word_if wi ();

	// ****************************************
	// Control register
	// ****************************************
	assign wr_mode = reg_wdata[IDW_CTRL_MODE_LSB +: 2];

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mode_reg <= IDW_MODE_RST;
		end else if (reg_wr && reg_addr == IDW_REG_CTRL) begin
			// Unsupported modes keep the old selection
			if (wr_mode <= IDW_MODE_MAX) begin
				mode_reg <= wr_mode; // R01
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			en_reg <= IDW_EN_RST;
		end else if (reg_wr && reg_addr == IDW_REG_CTRL) begin
			en_reg <= reg_wdata[IDW_CTRL_EN_LSB +: 6] & IDW_EN_SUP; // R19
		end
	end

	// ****************************************
	// Transfer sequencer
	// ****************************************
	assign take = word_req && state_reg == IDW_SERVE;
	assign last = cnt_reg == IDW_WORDS - 9'h001;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			IDW_IDLE: begin
				if (xfer_start) begin
					state_next = IDW_SERVE;
				end
			end
			IDW_SERVE: begin
				if (xfer_start) begin
					state_next = IDW_SERVE;
				end else if (take && last) begin
					state_next = IDW_IDLE;
				end
			end
			default: state_next = IDW_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= IDW_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// One coherent view of live state per block
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			snap_mode_reg <= IDW_MODE_RST;
			snap_en_reg <= IDW_EN_RST;
		end else if (xfer_start) begin
			snap_mode_reg <= mode_reg; // R25
			snap_en_reg <= en_reg; // R24
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_reg <= 9'h000;
		end else if (xfer_start) begin
			cnt_reg <= 9'h000;
		end else if (take) begin
			cnt_reg <= cnt_reg + 9'h001;
		end
	end

	// ****************************************
	// Word path
	// ****************************************
	assign wi.mode = snap_mode_reg;
	assign wi.en = snap_en_reg;
	assign wi.idx = word_idx;

	idw_word_enc u_enc (
		.wi(wi)
	);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			word_valid_reg <= 1'b0;
		end else begin
			word_valid_reg <= take && !xfer_start;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			word_data_reg <= IDW_W_NONE;
			idx_reg <= 8'h00;
		end else if (take && !xfer_start) begin
			word_data_reg <= wi.word;
			idx_reg <= word_idx;
		end
	end

	assign word_valid = word_valid_reg;
	assign word_data = word_data_reg; // R23
	assign xfer_active = state_reg == IDW_SERVE;

	// ****************************************
	// Register read port
	// ****************************************
	always_comb begin
		stat = '0;
		stat[IDW_STAT_ACT] = state_reg == IDW_SERVE;
		stat[IDW_STAT_MODE_LSB +: 2] = snap_mode_reg;
		stat[IDW_STAT_EN_LSB +: 6] = snap_en_reg;
		stat[IDW_STAT_CNT_LSB +: 9] = cnt_reg;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata_reg <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				IDW_REG_CTRL: begin
					rdata_reg <= '0;
					rdata_reg[IDW_CTRL_MODE_LSB +: 2] <= mode_reg;
					rdata_reg[IDW_CTRL_EN_LSB +: 6] <= en_reg;
				end
				IDW_REG_STAT: rdata_reg <= stat;
				default: rdata_reg <= '0;
			endcase
		end else begin
			rdata_reg <= '0;
		end
	end

	assign reg_rdata = rdata_reg;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	mdma_select_a: assert property ( // R01
		word_valid && idx_reg == IDW_W_MDMA
		|-> word_data[10:8] == idw_mode_bits(snap_mode_reg)
		&& $onehot(word_data[10:8]))
		else $error("word 63 mode bits wrong");

	mdma_support_a: assert property ( // R02
		word_valid && idx_reg == IDW_W_MDMA
		|-> word_data[2:0] == IDW_MDMA_SUP
		&& word_data[15:11] == 5'h00 && word_data[7:3] == 5'h00)
		else $error("word 63 fixed bits wrong");

	pio_modes_a: assert property ( // R03
		word_valid && idx_reg == IDW_W_PIO
		|-> word_data == {8'h00, IDW_PIO_ADV})
		else $error("word 64 wrong");

	cycle_times_a: assert property ( // R04
		word_valid && idx_reg == IDW_W_MDMA_MIN
		|-> word_data == IDW_T_MDMA_MIN)
		else $error("word 65 wrong");

	queue_depth_a: assert property ( // R10
		word_valid && idx_reg == IDW_W_QDEPTH
		|-> word_data == {11'h000, IDW_QDEPTH})
		else $error("word 75 wrong");

	minor_version_a: assert property ( // R12
		word_valid && idx_reg == IDW_W_MINOR
		|-> word_data != IDW_W_NONE && word_data != IDW_W_ALL)
		else $error("word 81 reads as unreported");

	support_valid_a: assert property ( // R13
		word_valid && idx_reg == IDW_W_SUP2
		|-> word_data[15:14] == 2'h1 && word_data != IDW_W_ALL)
		else $error("word 83 signature wrong");

	extension_a: assert property ( // R18
		word_valid && idx_reg == IDW_W_EXT
		|-> word_data == IDW_EXT)
		else $error("word 84 wrong");

	enabled_live_a: assert property ( // R20
		word_valid && idx_reg == IDW_W_ENA
		|-> word_data[8:5] == {snap_en_reg[IDW_EN_SRV],
		snap_en_reg[IDW_EN_REL], snap_en_reg[IDW_EN_LA],
		snap_en_reg[IDW_EN_WC]}
		&& word_data[1:0] == {snap_en_reg[IDW_EN_SEC],
		snap_en_reg[IDW_EN_SMART]})
		else $error("word 85 enable bits wrong");

	reserved_zero_a: assert property ( // R22
		word_valid && (idx_reg == 8'h45 || idx_reg == 8'h49
		|| idx_reg == 8'h4c || idx_reg == 8'h4f)
		|-> word_data == IDW_W_NONE)
		else $error("reserved word not zero");

	snap_hold_a: assert property ( // R25
		!xfer_start ##1 state_reg == IDW_SERVE
		|-> $stable(snap_mode_reg) && $stable(snap_en_reg))
		else $error("snapshot moved inside a block");

	snap_take_a: assert property ( // R24
		xfer_start |=> snap_mode_reg == $past(mode_reg)
		&& snap_en_reg == $past(en_reg))
		else $error("snapshot not taken at start");

	answer_a: assert property (
		take && !xfer_start |=> word_valid
		##1 !word_valid || $past(take))
		else $error("request not answered next cycle");

	mode_legal_a: assert property ( // R01
		mode_reg <= IDW_MODE_MAX)
		else $error("illegal mode selected");

	rec_cycle_a: assert property ( // R05
		word_valid && idx_reg == IDW_W_MDMA_REC
		|-> word_data == IDW_T_MDMA_REC)
		else $error("word 66 wrong");

	pio_cycle_a: assert property ( // R06
		word_valid && idx_reg == IDW_W_PIO_NFC
		|-> word_data == IDW_T_PIO_NFC)
		else $error("word 67 wrong");

	iordy_cycle_a: assert property ( // R07
		word_valid && idx_reg == IDW_W_PIO_FC
		|-> word_data == IDW_T_PIO_FC)
		else $error("word 68 wrong");

	packet_latency_a: assert property ( // R08
		word_valid && idx_reg == IDW_W_PKT_LAT
		|-> word_data == IDW_T_PKT_LAT)
		else $error("word 71 wrong");

	service_latency_a: assert property ( // R09
		word_valid && idx_reg == IDW_W_SRV_LAT
		|-> word_data == IDW_T_SRV_LAT)
		else $error("word 72 wrong");

	major_version_a: assert property ( // R11
		word_valid && idx_reg == IDW_W_MAJOR
		|-> word_data[15:5] == 11'h000 && !word_data[0]
		&& word_data != IDW_W_NONE)
		else $error("word 80 wrong");

	support_word_a: assert property ( // R15
		word_valid && idx_reg == IDW_W_SUP
		|-> word_data == IDW_SUP && !word_data[15] && !word_data[11])
		else $error("word 82 wrong");

	support2_fixed_a: assert property ( // R17
		word_valid && idx_reg == IDW_W_SUP2
		|-> word_data == IDW_SUP2 && word_data[13:5] == 9'h000
		&& word_data[3:1] == 3'h0)
		else $error("word 83 wrong");

	enabled_copy_a: assert property ( // R21
		word_valid && idx_reg == IDW_W_ENA
		|-> word_data[14:9] == IDW_SUP[14:9] && word_data[4:2] == IDW_SUP[4:2])
		else $error("word 85 fixed bits wrong");

	refused_req_a: assert property (
		word_req && (!xfer_active || xfer_start) |=> !word_valid)
		else $error("refused request answered");

	data_hold_a: assert property ( // R23
		!word_valid |-> $stable(word_data))
		else $error("word data moved without an answer");

	block_end_a: assert property (
		take && last && !xfer_start |=> !xfer_active)
		else $error("block did not end after last word");

	rdata_idle_a: assert property (
		!reg_rd |=> reg_rdata == '0)
		else $error("read data outside its cycle");
endmodule // idw_identify

// ===== bench/idw_host_model.sv
// Host side that fetches identify words from the generator.
// Assumes callers enter its tasks right after a rising edge of clk.
`timescale 1ns/10ps
module idw_host_model
	import idw_pkg::*;
(
	clk,
	xfer_start,
	word_req,
	word_idx,
	word_valid,
	word_data
);
	input wire logic clk;
	output logic xfer_start;
	output logic word_req;
	output logic [7:0] word_idx;
	input wire logic word_valid;
	input wire logic [15:0] word_data;

	initial begin
		xfer_start = 1'b0;
		word_req = 1'b0;
		word_idx = 8'h00;
	end

	// ****************************************
	// Host reading of the words
	// ****************************************
	// Zero or all ones means not reported
	function automatic logic reported(input logic [15:0] w);
		reported = (w !== IDW_W_NONE) && (w !== IDW_W_ALL);
	endfunction

	task automatic start_block();
		xfer_start <= 1'b1;
		@(posedge clk);
		xfer_start <= 1'b0;
	endtask

	// Valid flag above the word
	task automatic get_word(input logic [7:0] idx, output logic [16:0] got);
		word_req <= 1'b1;
		word_idx <= idx;
		@(posedge clk);
		word_req <= 1'b0;
		@(posedge clk);
		got = {word_valid, word_data};
	endtask

	// Back-to-back requests; a missing answer reads as unknown
	task automatic read_block(output logic [15:0] blk [256]);
		int i;
		start_block();
		for (i = 0; i < 257; i++) begin
			word_req <= (i < 256);
			word_idx <= i[7:0];
			@(posedge clk);
			if (i > 0) begin
				blk[i - 1] = word_valid ? word_data : 16'hxxxx;
			end
		end
	endtask
endmodule // idw_host_model

// ===== bench/idw_identify_tb_top.sv
// Self-checking bench of the identify word generator.
// Assumes the host model and the design share one clock.
`timescale 1ns/10ps
module idw_identify_tb_top
	import idw_pkg::*;
;
	logic clk;
	logic reset;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic xfer_start;
	logic word_req;
	logic [7:0] word_idx;
	logic word_valid;
	logic [15:0] word_data;
	logic xfer_active;
	int fail_count;
	int compares;
	int cycles;
	logic [15:0] blk [256];
	logic [16:0] got;
	logic [31:0] rd;

	idw_identify i_idw_identify (.clk(clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.xfer_start(xfer_start), .word_req(word_req), .word_idx(word_idx),
		.word_valid(word_valid), .word_data(word_data), .xfer_active(xfer_active));
	idw_host_model i_idw_host_model (.clk(clk), .xfer_start(xfer_start),
		.word_req(word_req), .word_idx(word_idx), .word_valid(word_valid),
		.word_data(word_data));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic test_done();
		$display("checks %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			test_done();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask

	function automatic logic [15:0] exp_word(input int i, input logic [1:0] m,
		input logic [5:0] e);
		case (i)
			63: exp_word = (16'h0100 << m) | {13'h0000, IDW_MDMA_SUP};
			64: exp_word = {8'h00, IDW_PIO_ADV};
			65: exp_word = IDW_T_MDMA_MIN;
			66: exp_word = IDW_T_MDMA_REC;
			67: exp_word = IDW_T_PIO_NFC;
			68: exp_word = IDW_T_PIO_FC;
			71: exp_word = IDW_T_PKT_LAT;
			72: exp_word = IDW_T_SRV_LAT;
			75: exp_word = {11'h000, IDW_QDEPTH};
			80: exp_word = IDW_MAJOR;
			81: exp_word = IDW_MINOR;
			82: exp_word = IDW_SUP;
			83: exp_word = IDW_SUP2;
			84: exp_word = 16'h4000;
			85: exp_word = (IDW_SUP & IDW_ENA_COPY) | {7'h00, e[5:2], 3'h0, e[1:0]};
			default: exp_word = 16'h0000;
		endcase
	endfunction

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		int k;
		int i;
		logic [5:0] ens [3];
		fail_count = 0;
		compares = 0;
		cycles = 0;
		ens = '{6'h15, 6'h2a, 6'h3f};
		reset = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h00000000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		reg_read(IDW_REG_CTRL, rd);
		check("ctrl reset", rd, 32'h00000000);
		reg_read(8'h08, rd);
		check("unmapped", rd, 32'h00000000);
		i_idw_host_model.get_word(8'h3f, got);
		check("idle request", {31'h0, got[16]}, 32'h00000000);
		$display("test reset done");
		for (k = 0; k < 3; k++) begin
			reg_write(IDW_REG_CTRL, {24'h000000, ens[k], k[1:0]});
			i_idw_host_model.read_block(blk);
			for (i = 0; i < 256; i++) begin
				check($sformatf("word %0d", i), {16'h0, blk[i]}, {16'h0, exp_word(i, k[1:0], ens[k])});
			end
			check("sup reported", {31'h0, i_idw_host_model.reported(blk[82])}, 32'h1);
			check("sup2 reported", {31'h0, i_idw_host_model.reported(blk[83])}, 32'h1);
			check("active end", {31'h0, xfer_active}, 32'h00000000);
			$display("test block %0d done", k);
		end
		reg_write(IDW_REG_CTRL, 32'h000000fd);
		i_idw_host_model.start_block();
		reg_write(IDW_REG_CTRL, 32'h00000002);
		i_idw_host_model.get_word(IDW_W_MDMA, got);
		check("snap mode", {15'h0, got}, {15'h0, 1'b1, exp_word(63, 2'h1, 6'h3f)});
		i_idw_host_model.get_word(IDW_W_ENA, got);
		check("snap en", {15'h0, got}, {15'h0, 1'b1, exp_word(85, 2'h1, 6'h3f)});
		check("active mid", {31'h0, xfer_active}, 32'h00000001);
		reg_read(IDW_REG_STAT, rd);
		check("stat", rd, 32'h00023f11);
		i_idw_host_model.read_block(blk);
		check("new mode", {16'h0, blk[63]}, {16'h0, exp_word(63, 2'h2, 6'h00)});
		check("new en", {16'h0, blk[85]}, {16'h0, exp_word(85, 2'h2, 6'h00)});
		reg_read(IDW_REG_STAT, rd);
		check("stat end", rd, 32'h01000020);
		$display("test snapshot done");
		reg_write(IDW_REG_CTRL, 32'h000000ff);
		reg_read(IDW_REG_CTRL, rd);
		check("mode three", rd, 32'h000000fe);
		i_idw_host_model.read_block(blk);
		check("one hot", {16'h0, blk[63]}, {16'h0, exp_word(63, 2'h2, 6'h3f)});
		$display("test mode refuse done");
		test_done();
	end
endmodule // idw_identify_tb_top
